/* shared/lpw_pkg.sv */
// Purpose: Constants and types for the low power mode and wake controller.
// Assumes: Single 40 MHz system clock, all control bits arrive as plain ports.
// Notes: Bit positions of the start-enable words are fixed here for the whole block.
// Behaviour
// - Deep power-down loses all state; reset reinitialises.
// - Functional pins tri-stated in deep power-down.
// - Clock alarm wakes from deep power-down.
// - Sleep wakes on any controller-enabled interrupt.
// - Hardware wake request wakes sleep and deep-sleep.
// - Pin interrupt needs controller and start-enable bit.
// - Brownout interrupt needs four enables to wake.
// - Brownout reset wakes when reset enabled.
// - Watchdog interrupt needs oscillator, feed, enables.
// - Watchdog reset needs oscillator, enable, reset, feed.
// - Second alarm needs count, oscillator, clock, enable.
// - Millisecond timer wakes deep-sleep and power-down.
// - Micro-tick timer needs oscillator, clock, enable.
// - Serial unit wakes in sync slave or 32k.
// - Sync serial and two-wire wake in slave mode.
// - USB need-clock request wakes deep-sleep.
// - DMA active sleep, limited deep-sleep, off power-down.
// - Sleep stops processor clock, keeps all state.
// - Deep-sleep gates main, peripheral clocks; flash standby.
// - Reset pin always wakes deep power-down.
package lpw_pkg;

  // Power modes requested by software.
  typedef enum logic [1:0] {
    LPW_REQ_ACTIVE = 2'h0,
    LPW_REQ_SLEEP  = 2'h1,
    LPW_REQ_DSLEEP = 2'h2,
    LPW_REQ_DPD    = 2'h3
  } lpw_req_t;

  // Controller state, codes left to the tool.
  typedef enum {
    LPW_ACTIVE,
    LPW_SLEEP,
    LPW_DSLEEP,
    LPW_DPD
  } lpw_state_t;

  // Widths of the interrupt and start-enable words.
  localparam int LPW_IRQ_W  = 32;
  localparam int LPW_PIN_W  = 8;
  localparam int LPW_PINS_W = 16;

  // Bit positions inside wake_start_enable_0.
  localparam int LPW_SE0_BROWNOUT = 0;
  localparam int LPW_SE0_WATCHDOG = 1;
  localparam int LPW_SE0_ALARM    = 2;
  localparam int LPW_SE0_MSWAKE   = 3;
  localparam int LPW_SE0_UTICK    = 4;

  // Matching bit positions in the core interrupt controller enables.
  localparam int LPW_IRQ_BROWNOUT = 0;
  localparam int LPW_IRQ_WATCHDOG = 1;
  localparam int LPW_IRQ_PIN0     = 8;

  // Bit positions in brownout_control and watchdog_setup.
  localparam int LPW_BOD_RST_EN = 0;
  localparam int LPW_BOD_IRQ_EN = 1;
  localparam int LPW_WDS_EN     = 0;
  localparam int LPW_WDS_RESET  = 1;
  localparam int LPW_WDS_IRQ    = 2;

  // Reset values.
  localparam logic [1:0] LPW_SYNC_RST = 2'h0;

endpackage

/* rtl/lpw_wake_ctrl.sv */
// Purpose: Tracks reduced power modes, gates clocks and qualifies wake sources.
// Assumes: Wake events are levels from other domains and are synchronised here.
// Notes: Deep power-down exit is reported as a reset request, never a resume.
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_ctrl (
  input  wire logic                        i_sys_clk,            // System clock, 40 MHz.
  input  wire logic                        i_rstn,               // Async reset, active low.
  input  wire lpw_pkg::lpw_req_t           i_mode_req,           // Requested power mode.
  input  wire logic                        i_mode_go,            // Pulse: enter requested mode.
  input  wire logic [lpw_pkg::LPW_IRQ_W-1:0] i_irq_pend,         // Pending interrupts (async).
  input  wire logic [lpw_pkg::LPW_IRQ_W-1:0] i_irq_en,           // Interrupt controller enables.
  input  wire logic [lpw_pkg::LPW_IRQ_W-1:0] i_wake_start_enable_0, // Start-enable word 0.
  input  wire logic [lpw_pkg::LPW_IRQ_W-1:0] i_wake_start_enable_1, // Start-enable word 1.
  input  wire logic [lpw_pkg::LPW_PINS_W-1:0] i_pin_irq,         // Pin interrupts (async).
  input  wire logic                        i_hardware_wake_request, // Serial activity wake.
  input  wire logic                        i_bod_irq,            // Brownout interrupt.
  input  wire logic                        i_bod_reset,          // Brownout reset event.
  input  wire logic [7:0]                  i_brownout_control,   // Brownout control bits.
  input  wire logic                        i_bod_keep_run,       // Detector kept running.
  input  wire logic                        i_wdt_irq,            // Watchdog interrupt.
  input  wire logic                        i_wdt_reset,          // Watchdog reset event.
  input  wire logic [7:0]                  i_watchdog_setup,     // Watchdog setup bits.
  input  wire logic                        i_wdt_fed,            // Watchdog has been fed.
  input  wire logic                        i_wdt_osc_on,         // Watchdog osc powered.
  input  wire logic                        i_wdt_osc_keep,       // Watchdog osc kept running.
  input  wire logic                        i_alarm_irq,          // Second alarm fired.
  input  wire logic                        i_alarm_started,      // Time-out written to counter.
  input  wire logic                        i_osc_1hz_on,         // 1 Hz oscillator on.
  input  wire logic                        i_osc_1khz_on,        // 1 kHz oscillator on.
  input  wire logic                        i_rtc_bus_clk_on,     // RTC bus clock enabled.
  input  wire logic                        i_ms_wake_irq,        // Millisecond timer time-out.
  input  wire logic                        i_ms_wake_started,    // Wake register written.
  input  wire logic                        i_utick_irq,          // Micro-tick time-out.
  input  wire logic                        i_utick_started,      // Timer control started.
  input  wire logic                        i_utick_clk_on,       // Micro-tick bus clock.
  input  wire logic                        i_usart_irq,          // Serial unit interrupt.
  input  wire logic                        i_usart_sync_slave,   // Sync slave mode.
  input  wire logic                        i_usart_32k_mode,     // 32 kHz clock mode.
  input  wire logic                        i_spi_irq,            // Sync serial interrupt.
  input  wire logic                        i_spi_slave,          // Sync serial slave mode.
  input  wire logic                        i_i2c_irq,            // Two-wire interrupt.
  input  wire logic                        i_i2c_slave,          // Two-wire slave mode.
  input  wire logic                        i_usb_need_clk,       // USB needs a clock.
  input  wire logic                        i_dma_dsleep_cfg,     // DMA allowed in deep-sleep.
  input  wire logic                        i_reset_pin_n,        // Reset pin, active low.
  output logic                             o_cpu_clk_en,         // Processor clock enable.
  output logic                             o_main_clk_en,        // Main clock enable.
  output logic                             o_periph_clk_en,      // Peripheral clocks enable.
  output logic                             o_flash_standby,      // Flash in standby.
  output logic                             o_dma_en,             // DMA may run.
  output logic                             o_pins_oe_n,          // Pin drive disable (1 = hi-Z).
  output logic                             o_state_lost,         // Retained state invalid.
  output logic                             o_chip_reset_req,     // Full reset request.
  output logic [1:0]                       o_mode,               // Current mode.
  output logic                             o_wake                // Pulse: wake event taken.
);
  import lpw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers: every asynchronous event passes two flops first.

  localparam int EV_W = LPW_PINS_W + 15;

  logic [EV_W-1:0] sync_a;  // First stage, read only by sync_b.
  logic [EV_W-1:0] sync_b;  // Second stage, used by logic.
  logic [LPW_IRQ_W-1:0] irq_a;  // First stage of pending interrupts.
  logic [LPW_IRQ_W-1:0] irq_b;  // Second stage of pending interrupts.

  // Event bundle packed so one pair of flops serves them all.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_a <= '0;
      sync_b <= '0;
      irq_a  <= '0;
      irq_b  <= '0;
    end else begin
      sync_a <= {i_pin_irq, i_hardware_wake_request, i_bod_irq, i_bod_reset, i_wdt_irq,
                 i_wdt_reset, i_alarm_irq, i_ms_wake_irq, i_utick_irq, i_usart_irq,
                 i_spi_irq, i_i2c_irq, i_usb_need_clk, ~i_reset_pin_n, 1'b0, 1'b0};
      sync_b <= sync_a;
      irq_a  <= i_irq_pend;
      irq_b  <= irq_a;
    end
  end

  logic [LPW_PINS_W-1:0] s_pin;  // Synchronised pin interrupts.
  logic s_hw, s_bodi, s_bodr, s_wdti, s_wdtr, s_alarm, s_ms, s_ut;
  logic s_usart, s_spi, s_i2c, s_usb, s_rstpin, s_pad0, s_pad1;
  assign {s_pin, s_hw, s_bodi, s_bodr, s_wdti, s_wdtr, s_alarm, s_ms, s_ut,
          s_usart, s_spi, s_i2c, s_usb, s_rstpin, s_pad0, s_pad1} = sync_b;

  ////////////////////////////////////////////////////////////////////////////////
  // Wake qualification, one term per documented source.

  // Interrupt enabled both at the core controller and in start-enable word 0.
  function automatic logic se0_ok(input int irq_bit, input int se_bit);
    se0_ok = i_irq_en[irq_bit] && i_wake_start_enable_0[se_bit];
  endfunction

  logic [LPW_PINS_W-1:0] pin_se;  // Pin start enables from either word.
  logic wk_pin, wk_bodi, wk_bodr, wk_wdti, wk_wdtr, wk_alarm, wk_ms, wk_ut, wk_serial;
  logic wk_sleep, wk_dsleep, wk_dpd;

  always_comb begin
    pin_se = i_wake_start_enable_0[LPW_IRQ_PIN0 +: LPW_PINS_W] |
             i_wake_start_enable_1[LPW_PINS_W-1:0];
    wk_pin = |(s_pin & pin_se & i_irq_en[LPW_IRQ_PIN0 +: LPW_PINS_W]);
    wk_bodi = s_bodi && se0_ok(LPW_IRQ_BROWNOUT, LPW_SE0_BROWNOUT) &&
              i_brownout_control[LPW_BOD_IRQ_EN] && i_bod_keep_run;
    wk_bodr = s_bodr && i_brownout_control[LPW_BOD_RST_EN];
    wk_wdti = s_wdti && i_wdt_osc_on && i_wdt_osc_keep && i_wdt_fed &&
              i_watchdog_setup[LPW_WDS_EN] && i_watchdog_setup[LPW_WDS_IRQ] &&
              se0_ok(LPW_IRQ_WATCHDOG, LPW_SE0_WATCHDOG);
    wk_wdtr = s_wdtr && i_wdt_osc_on && i_wdt_fed && i_watchdog_setup[LPW_WDS_EN] &&
              i_watchdog_setup[LPW_WDS_RESET];
    wk_alarm = s_alarm && i_alarm_started && i_osc_1hz_on && i_rtc_bus_clk_on &&
               i_wake_start_enable_0[LPW_SE0_ALARM];
    wk_ms = s_ms && i_ms_wake_started && i_osc_1hz_on && i_osc_1khz_on;
    wk_ut = s_ut && i_utick_started && i_wdt_osc_on && i_utick_clk_on &&
            i_wake_start_enable_0[LPW_SE0_UTICK];
    wk_serial = (s_usart && (i_usart_sync_slave || i_usart_32k_mode)) ||
                (s_spi && i_spi_slave) || (s_i2c && i_i2c_slave) ||
                s_usb;
    // Sleep: any enabled interrupt or the hardware request.
    wk_sleep = (|(irq_b & i_irq_en)) || s_hw;
    wk_dsleep = wk_pin || wk_bodi || wk_bodr || wk_wdti || wk_wdtr || wk_alarm ||
                wk_ms || wk_ut || wk_serial || s_hw || s_rstpin;
    // Deep power-down keeps only the always-on alarm, timer and reset pin.
    wk_dpd = (s_alarm && i_alarm_started && i_osc_1hz_on) ||
             (s_ms && i_ms_wake_started && i_osc_1hz_on && i_osc_1khz_on) ||
             s_rstpin;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode state machine.

  lpw_state_t state;       // Current mode.
  lpw_state_t next_state;  // Mode after this edge.
  logic       next_wake;   // Wake taken this cycle.

  // Leave a low power mode on the first qualified event; only active accepts requests.
  always_comb begin
    next_state = state;
    next_wake  = 1'b0;
    unique case (state)
      LPW_ACTIVE: begin
        if (i_mode_go) begin
          unique case (i_mode_req)
            LPW_REQ_SLEEP:  next_state = LPW_SLEEP;
            LPW_REQ_DSLEEP: next_state = LPW_DSLEEP;
            LPW_REQ_DPD:    next_state = LPW_DPD;
            LPW_REQ_ACTIVE: next_state = LPW_ACTIVE;
          endcase
        end
      end
      LPW_SLEEP: begin
        if (wk_sleep) begin
          next_state = LPW_ACTIVE;
          next_wake  = 1'b1;
        end
      end
      LPW_DSLEEP: begin
        if (wk_dsleep) begin
          next_state = LPW_ACTIVE;
          next_wake  = 1'b1;
        end
      end
      LPW_DPD: begin
        if (wk_dpd) begin
          next_state = LPW_ACTIVE;
          next_wake  = 1'b1;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= LPW_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // Wake pulse, registered so it is glitch free.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= next_wake;
    end
  end

  // Exit from deep power-down requests a full reset, since nothing was retained.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_chip_reset_req <= 1'b0;
    end else begin
      o_chip_reset_req <= (state == LPW_DPD) && wk_dpd;
    end
  end

  // Lost flag sets on deep power-down entry and is cleared only by reset.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_state_lost <= 1'b0;
    end else if (next_state == LPW_DPD) begin
      o_state_lost <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock gating and power outputs, registered from the next mode.

  // Sleep stops only the processor; deep-sleep also gates main and peripheral
  // clocks and parks flash. Retention in sleep is implicit: nothing is reset.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cpu_clk_en    <= 1'b1;
      o_main_clk_en   <= 1'b1;
      o_periph_clk_en <= 1'b1;
      o_flash_standby <= 1'b0;
      o_pins_oe_n     <= 1'b0;
    end else begin
      o_cpu_clk_en    <= (next_state == LPW_ACTIVE);
      o_main_clk_en   <= (next_state == LPW_ACTIVE) || (next_state == LPW_SLEEP);
      o_periph_clk_en <= (next_state == LPW_ACTIVE) || (next_state == LPW_SLEEP);
      o_flash_standby <= (next_state == LPW_DSLEEP);
      o_pins_oe_n     <= (next_state == LPW_DPD);
    end
  end

  // DMA runs in active and sleep, in deep-sleep only when configured.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dma_en <= 1'b1;
    end else begin
      unique case (next_state)
        LPW_ACTIVE, LPW_SLEEP: o_dma_en <= 1'b1;
        LPW_DSLEEP:            o_dma_en <= i_dma_dsleep_cfg;
        LPW_DPD:               o_dma_en <= 1'b0;
      endcase
    end
  end

  // Mode code visible to software.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mode <= LPW_SYNC_RST;
    end else begin
      unique case (next_state)
        LPW_ACTIVE: o_mode <= LPW_REQ_ACTIVE;
        LPW_SLEEP:  o_mode <= LPW_REQ_SLEEP;
        LPW_DSLEEP: o_mode <= LPW_REQ_DSLEEP;
        LPW_DPD:    o_mode <= LPW_REQ_DPD;
      endcase
    end
  end

endmodule
`default_nettype wire

/* testbench/lpw_wake_ctrl_sva.sv */
// Purpose: Concurrent checks on the mode and wake ports of the wake controller.
// Assumes: One clock domain; wake events pass a two-flop synchroniser.
// Notes: Wake checks need three sampled edges of a qualified level.
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_ctrl_sva (
  input wire logic                            i_sys_clk,     // System clock.
  input wire logic                            i_rstn,        // Reset, active low.
  input wire lpw_pkg::lpw_req_t               i_mode_req,    // Requested mode.
  input wire logic                            i_mode_go,     // Mode request strobe.
  input wire logic [lpw_pkg::LPW_IRQ_W-1:0]   i_irq_pend,    // Pending interrupts.
  input wire logic [lpw_pkg::LPW_IRQ_W-1:0]   i_irq_en,      // Interrupt enables.
  input wire logic [lpw_pkg::LPW_IRQ_W-1:0]   i_wake_start_enable_0, // Start word 0.
  input wire logic [lpw_pkg::LPW_IRQ_W-1:0]   i_wake_start_enable_1, // Start word 1.
  input wire logic [lpw_pkg::LPW_PINS_W-1:0]  i_pin_irq,     // Pin interrupts.
  input wire logic                            i_alarm_irq,   // Second alarm.
  input wire logic                            i_alarm_started, // Alarm armed.
  input wire logic                            i_osc_1hz_on,  // 1 Hz oscillator.
  input wire logic                            i_reset_pin_n, // Reset pin.
  input wire logic                            o_cpu_clk_en,  // Processor clock.
  input wire logic                            o_main_clk_en, // Main clock.
  input wire logic                            o_periph_clk_en, // Peripheral clocks.
  input wire logic                            o_flash_standby, // Flash standby.
  input wire logic                            o_dma_en,      // DMA enable.
  input wire logic                            o_pins_oe_n,   // Pins released.
  input wire logic                            o_state_lost,  // State lost flag.
  input wire logic                            o_chip_reset_req, // Reset request.
  input wire logic [1:0]                      o_mode,        // Current mode.
  input wire logic                            o_wake         // Wake pulse.
);
  import lpw_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  //////////////////////////////////////////////////////////////////////////////
  // A qualified level must be seen on three edges to pass the synchroniser.
  sequence s_sleep_irq;
    (o_mode == 2'h1 && |(i_irq_pend & i_irq_en))[*3];
  endsequence
  sequence s_pin_ds;
    (o_mode == 2'h2 && i_pin_irq[0] && i_irq_en[8] &&
     (i_wake_start_enable_0[8] || i_wake_start_enable_1[0]))[*3];
  endsequence
  sequence s_dpd_leave;
    o_mode == 2'h3 ##1 o_mode == 2'h0;
  endsequence
  go_mode_a: assert property ((o_mode == 2'h0 && i_mode_go) |=> o_mode == $past(i_mode_req))
    else $error("mode did not follow request");
  active_clk_a: assert property (o_mode == 2'h0 |-> o_cpu_clk_en && o_main_clk_en &&
    o_periph_clk_en && !o_pins_oe_n && !o_flash_standby) else $error("active outputs wrong");
  sleep_cpu_a: assert property (o_mode == 2'h1 |-> !o_cpu_clk_en && o_dma_en && !o_pins_oe_n)
    else $error("sleep outputs wrong");
  dsleep_gate_a: assert property (o_mode == 2'h2 |-> !o_cpu_clk_en && !o_main_clk_en &&
    !o_periph_clk_en && o_flash_standby) else $error("deep-sleep gating wrong");
  dpd_pins_a: assert property (o_mode == 2'h3 |-> o_pins_oe_n && !o_dma_en && o_state_lost)
    else $error("power-down outputs wrong");
  lost_sticky_a: assert property (o_state_lost |=> o_state_lost)
    else $error("state lost flag dropped");
  wake_pulse_a: assert property (o_wake |-> o_mode == 2'h0 ##1 !o_wake)
    else $error("wake pulse wrong");
  dpd_exit_a: assert property (s_dpd_leave |-> o_chip_reset_req && o_wake)
    else $error("power-down exit without reset");
  sleep_wake_a: assert property (s_sleep_irq |=> o_mode == 2'h0)
    else $error("sleep missed interrupt");
  pin_wake_a: assert property (s_pin_ds |=> o_mode == 2'h0)
    else $error("deep-sleep missed pin");
  alarm_wake_a: assert property ((o_mode == 2'h3 && i_alarm_irq && i_alarm_started &&
    i_osc_1hz_on)[*3] |=> o_chip_reset_req) else $error("alarm missed");
  rpin_wake_a: assert property ((o_mode == 2'h3 && !i_reset_pin_n)[*3] |=> o_chip_reset_req)
    else $error("reset pin missed");
endmodule
bind lpw_wake_ctrl lpw_wake_ctrl_sva lpw_wake_ctrl_sva_inst (.*);
`default_nettype wire

/* testbench/lpw_tb_top.sv */
// Purpose: Directed tests of mode entry and wake qualification.
// Assumes: Inputs change at the falling edge; enables on except en[12] (32 kHz mode) and word se1 unless a test changes them.
// Notes: Event inputs are packed in ev, single-bit enables in en.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lpw_pkg::*;
  logic i_sys_clk, i_rstn, i_mode_go, dma_cfg, cpu, mclk, pclk, flash, dma, oen, lost, rreq, wake;
  lpw_req_t    i_mode_req;
  logic [15:0] ev;      // 0 hw,1 bod,2 bodrst,3 wdt,4 wdtrst,5 alarm,6 ms,7 utick,8..11 serial/usb
  logic [14:0] en;      // Single-bit qualifiers of the wake sources.
  logic [31:0] irq_en, se0, se1;
  logic [7:0]  bc, ws;
  logic [1:0]  mode;
  int          err_total, checked;
  lpw_wake_ctrl lpw_wake_ctrl_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_mode_req(i_mode_req),
    .i_mode_go(i_mode_go), .i_irq_pend({26'h0, ev[14], 5'h0}), .i_irq_en(irq_en),
    .i_wake_start_enable_0(se0), .i_wake_start_enable_1(se1), .i_pin_irq({15'h0, ev[13]}),
    .i_hardware_wake_request(ev[0]), .i_bod_irq(ev[1]), .i_bod_reset(ev[2]),
    .i_brownout_control(bc), .i_bod_keep_run(en[0]), .i_wdt_irq(ev[3]), .i_wdt_reset(ev[4]),
    .i_watchdog_setup(ws), .i_wdt_fed(en[1]), .i_wdt_osc_on(en[2]), .i_wdt_osc_keep(en[3]),
    .i_alarm_irq(ev[5]), .i_alarm_started(en[4]), .i_osc_1hz_on(en[5]), .i_osc_1khz_on(en[6]),
    .i_rtc_bus_clk_on(en[7]), .i_ms_wake_irq(ev[6]), .i_ms_wake_started(en[8]),
    .i_utick_irq(ev[7]), .i_utick_started(en[9]), .i_utick_clk_on(en[10]), .i_usart_irq(ev[8]),
    .i_usart_sync_slave(en[11]), .i_usart_32k_mode(en[12]), .i_spi_irq(ev[9]),
    .i_spi_slave(en[13]), .i_i2c_irq(ev[10]), .i_i2c_slave(en[14]), .i_usb_need_clk(ev[11]),
    .i_dma_dsleep_cfg(dma_cfg), .i_reset_pin_n(~ev[12]), .o_cpu_clk_en(cpu), .o_main_clk_en(mclk),
    .o_periph_clk_en(pclk), .o_flash_standby(flash), .o_dma_en(dma), .o_pins_oe_n(oen),
    .o_state_lost(lost), .o_chip_reset_req(rreq), .o_mode(mode), .o_wake(wake));
  //////////////////////////////////////////////////////////////////////////////
  // Compare one value; case inequality so an unknown never matches.
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request a mode at a falling edge and check what the controller gates.
  task automatic go_to(input lpw_req_t m);
    i_mode_req = m;
    i_mode_go = 1'b1;
    @(negedge i_sys_clk);
    i_mode_go = 1'b0;
    chk("mode", mode, m);
    chk("cpu", cpu, 1'b0);
    chk("pins", oen, m == LPW_REQ_DPD);
    chk("dma", dma, m == LPW_REQ_SLEEP || (m == LPW_REQ_DSLEEP && dma_cfg));
    if (m == LPW_REQ_DSLEEP) chk("gate", {mclk, pclk, flash}, 3'b001);
    if (m == LPW_REQ_SLEEP) chk("sgate", {mclk, pclk, flash}, 3'b110);
    if (m == LPW_REQ_DPD) chk("lost", lost, 1'b1);
  endtask
  // Raise one event and record the cycle of the wake pulse; zero means none.
  task automatic hit(input int s, input int lat);
    int pm, got;
    logic r;
    pm = mode;
    got = 0;
    r = 1'b0;
    ev[s] = 1'b1;
    for (int n = 1; n <= 6; n++) begin
      @(negedge i_sys_clk);
      if (wake === 1'b1 && got == 0) begin
        got = n;
        r = rreq;
      end
    end
    ev = '0;
    // Let the synchroniser drain so the next entry starts clean.
    repeat (3) @(negedge i_sys_clk);
    chk("latency", got, lat);
    chk("mode", mode, lat != 0 ? 0 : pm);
    if (lat != 0) chk("rstreq", r, pm == 3);
    $display("test source %0d mode %0d done", s, pm);
  endtask
  // Drop one qualifier: the event is ignored, then taken once restored.
  task automatic neg(input int s, input lpw_req_t m, input int k);
    en[k] = 1'b0;
    go_to(m);
    hit(s, 0);
    en[k] = 1'b1;
    hit(s, 3);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // About 490 cycles of tests; the limit leaves wide margin.
  initial begin
    #150000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    {i_rstn, i_mode_go, dma_cfg, ev} = '0;
    i_mode_req = LPW_REQ_ACTIVE;
    en = 15'h6fff;
    {irq_en, se0, se1} = {32'hffff_ffff, 32'hffff_ffff, 32'h0000_0000};
    bc = 8'h03;
    ws = 8'h07;
    repeat (12) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    chk("reset", {cpu, mclk, pclk, flash, dma, oen, lost, rreq, wake, mode}, 11'h740);
    irq_en[5] = 1'b0;
    go_to(LPW_REQ_SLEEP);
    hit(14, 0);
    irq_en[5] = 1'b1;
    hit(14, 3);
    go_to(LPW_REQ_SLEEP);
    hit(0, 3);
    // A request outside active must be ignored.
    go_to(LPW_REQ_DSLEEP);
    // Pulse the strobe by hand; go_to would expect the new mode.
    i_mode_req = LPW_REQ_SLEEP;
    i_mode_go = 1'b1;
    @(negedge i_sys_clk);
    i_mode_go = 1'b0;
    @(negedge i_sys_clk);
    chk("refused", mode, 2'h2);
    hit(13, 3);
    for (int s = 0; s < 13; s++) begin
      go_to(LPW_REQ_DSLEEP);
      hit(s, 3);
    end
    neg(1, LPW_REQ_DSLEEP, 0);
    neg(3, LPW_REQ_DSLEEP, 1);
    neg(4, LPW_REQ_DSLEEP, 2);
    neg(5, LPW_REQ_DSLEEP, 7);
    neg(6, LPW_REQ_DSLEEP, 6);
    neg(7, LPW_REQ_DSLEEP, 10);
    neg(8, LPW_REQ_DSLEEP, 11);
    neg(9, LPW_REQ_DSLEEP, 13);
    neg(10, LPW_REQ_DSLEEP, 14);
    // Only the 32 kHz mode qualifies the serial unit here.
    en[11] = 1'b0;
    neg(8, LPW_REQ_DSLEEP, 12);
    en[11] = 1'b1;
    en[12] = 1'b0;
    dma_cfg = 1'b1;
    se0[8] = 1'b0;
    go_to(LPW_REQ_DSLEEP);
    hit(13, 0);
    se1[0] = 1'b1;
    hit(13, 3);
    bc = 8'h02;
    go_to(LPW_REQ_DSLEEP);
    hit(2, 0);
    bc = 8'h03;
    hit(2, 3);
    ws = 8'h03;
    go_to(LPW_REQ_DSLEEP);
    hit(3, 0);
    ws = 8'h07;
    hit(3, 3);
    go_to(LPW_REQ_DPD);
    hit(0, 0);
    hit(13, 0);
    hit(12, 3);
    go_to(LPW_REQ_DPD);
    hit(6, 3);
    neg(5, LPW_REQ_DPD, 5);
    chk("sticky", lost, 1'b1);
    i_rstn = 1'b0;
    @(negedge i_sys_clk);
    i_rstn = 1'b1;
    chk("cleared", lost, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
